// *** ccc_pkg.sv ***
`default_nettype none
package ccc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port geometry
    localparam int CCC_AW = 3;
    localparam int CCC_DW = 10;
    localparam int CCC_SW = 16;

    localparam logic [2:0] CCC_REG_REF_CTRL   = 3'h0;
    localparam logic [2:0] CCC_REG_CLK_DIV    = 3'h1;
    localparam logic [2:0] CCC_REG_FILT_CTRL  = 3'h2;
    localparam logic [2:0] CCC_REG_ADC_CTRL   = 3'h3;
    localparam logic [2:0] CCC_REG_PEAK_LEVEL = 3'h4;
    localparam logic [2:0] CCC_REG_DAC_VOL    = 3'h5;
    localparam logic [2:0] CCC_REG_DAC_CTRL   = 3'h6;
    localparam logic [2:0] CCC_REG_STATUS     = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CCC_REF_DIS_BIT    = 0;
    localparam int CCC_DIV1_LSB       = 0;
    localparam int CCC_DIV2_LSB       = 2;
    localparam int CCC_DIV3_LSB       = 4;
    localparam int CCC_LOW_DELAY_BIT  = 0;
    localparam int CCC_GAIN_LSB       = 0;
    localparam int CCC_ADC_MUTE_BIT   = 3;
    localparam int CCC_PEAK_EN_BIT    = 4;
    localparam int CCC_DAC_MUTE_BIT   = 0;
    localparam int CCC_ST_SLAVE_BIT   = 0;
    localparam int CCC_ST_BUSY_BIT    = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and codes
    localparam logic [1:0] CCC_DIV_BY1      = 2'h0;
    localparam logic [1:0] CCC_DIV_BY2      = 2'h1;
    localparam logic [1:0] CCC_DIV_BY3      = 2'h2;
    localparam logic [1:0] CCC_DIV_BY4      = 2'h2;
    localparam logic [2:0] CCC_GAIN_RST     = 3'h0;
    localparam logic [2:0] CCC_GAIN_MAX     = 3'h4;
    localparam logic [9:0] CCC_DAC_VOL_RST  = 10'h000;
    localparam logic [5:0] CCC_PEAK_CLEAR   = 6'h3f;
    localparam logic [10:0] CCC_UNITY_GAIN  = 11'h400;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts
    localparam logic [11:0] CCC_INIT_CYCLES = 12'hc00;
    localparam logic [7:0]  CCC_NORM_LAST   = 8'hff;
    localparam logic [6:0]  CCC_FAST_LAST   = 7'h7f;
    localparam logic [1:0]  CCC_ADC_MOD_PH  = 2'h3;

    // Rounded 20*log10(1 + m/8) for m = 0..7, three bits per entry
    localparam logic [23:0] CCC_FRAC_DB = {3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

    typedef enum logic [1:0] {
        CCC_ST_RESET = 2'b00,
        CCC_ST_INIT  = 2'b01,
        CCC_ST_RUN   = 2'b10
    } ccc_state_t;

    // Level below full scale, in whole dB, of a 16-bit magnitude
    function automatic logic [5:0] ccc_peak_level(input logic [15:0] mag);
        logic [4:0]  lz;
        logic        found;
        logic [15:0] norm;
        logic [2:0]  frac;
        logic [7:0]  att;
        lz    = 5'h10;
        found = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (!found && mag[i]) begin
                found = 1'b1;
                lz    = 5'(15 - i);
            end
        end
        norm = mag << lz;
        frac = norm[14:12];
        att  = 8'({3'h0, lz} * 8'h06) - {5'h0, CCC_FRAC_DB[{frac, 1'b0} + {2'h0, frac} +: 3]};
        if (!found || att > 8'h3f) begin
            return CCC_PEAK_CLEAR;
        end
        return att[5:0];
    endfunction : ccc_peak_level

endpackage : ccc_pkg
`default_nettype wire

// *** ccc_div_stage.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccc_div_stage
    import ccc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clear,
    input  wire logic       tick_in,
    input  wire logic [1:0] last,
    output var  logic       tick_out
);

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    ////////////////////////////////////////////////////////////////////////////
    // Enable pulse every (last + 1) input pulses; no derived clock is made
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (clear) begin
            cnt_d = 2'h0;
        end else if (tick_in) begin
            // Compare with >= so a ratio lowered mid-count cannot run away
            if (cnt_q >= last) begin
                cnt_d  = 2'h0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q  <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;

endmodule : ccc_div_stage
`default_nettype wire

// *** ccc_buf2.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccc_buf2
    import ccc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              flush,
    input  wire logic              in_valid,
    output var  logic              in_ready,
    input  wire logic [CCC_SW-1:0] in_data,
    output var  logic              out_valid,
    input  wire logic              out_ready,
    output var  logic [CCC_SW-1:0] out_data
);

    logic [CCC_SW-1:0] slot0_q, slot0_d;
    logic [CCC_SW-1:0] slot1_q, slot1_d;
    logic              v0_q,    v0_d;
    logic              v1_q,    v1_d;
    logic              push;
    logic              pop;

    ////////////////////////////////////////////////////////////////////////////
    // Slot 0 is the head; ready and valid are plain flop bits
    always_comb begin
        push    = in_valid && !v1_q;
        pop     = out_ready && v0_q;
        slot0_d = slot0_q;
        slot1_d = slot1_q;
        v0_d    = v0_q;
        v1_d    = v1_q;
        if (flush) begin
            v0_d = 1'b0;
            v1_d = 1'b0;
        end else if (push && pop) begin
            slot0_d = in_data;
        end else if (pop) begin
            slot0_d = slot1_q;
            v0_d    = v1_q;
            v1_d    = 1'b0;
        end else if (push) begin
            if (!v0_q) begin
                slot0_d = in_data;
                v0_d    = 1'b1;
            end else begin
                slot1_d = in_data;
                v1_d    = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            slot0_q <= '0;
            slot1_q <= '0;
            v0_q    <= 1'b0;
            v1_q    <= 1'b0;
        end else begin
            slot0_q <= slot0_d;
            slot1_q <= slot1_d;
            v0_q    <= v0_d;
            v1_q    <= v1_d;
        end
    end

    assign in_ready  = !v1_q;
    assign out_valid = v0_q;
    assign out_data  = slot0_q;

endmodule : ccc_buf2
`default_nettype wire

// *** ccc_core.sv ***
// Notes on behaviour
// - Serial data input level is captured when reset is released.
// - Captured high means slave, low means master driving sync and bit clock.
// - After reset, 3073 cycles restore defaults and purge samples; writes ignored.
// - ADC gain field picks five 3 dB steps, 0 dB to 12 dB.
// - ADC mute bit zeroes ADC samples, independent of gain.
// - ADC modulator enable runs at 64 times the sample rate in normal mode, 32 times in low-delay mode.
// - Peak enable tracks the loudest ADC sample as 0 to -63 dB.
// - Reading the peak register returns it, then restarts tracking.
// - DAC mute and DAC volume act independently.
// - Ten-bit DAC attenuation gives 1024 steps on output samples.
// - Low-delay option makes the sample tick the divided clock over 128.
// - A control bit switches the on-chip reference off.
// - In normal mode the sample tick is the divided clock over 256.
// - First two dividers select divide by 1, 2 or 3.
// - Third divider selects divide by 1, 2 or 4 and forms the divided clock.
// - Default dividers give a sample rate of master clock over 256.
// - ADC modulator at a quarter, DAC modulator at half the divided clock.
`timescale 1ns/1ps
`default_nettype none
module ccc_core
    import ccc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [CCC_AW-1:0] reg_addr,
    input  wire logic [CCC_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [CCC_DW-1:0] reg_rdata,
    input  wire logic              serial_din,
    output var  logic              slave_mode,
    output var  logic              serial_bit_clock_oe,
    output var  logic              frame_sync_oe,
    output var  logic              init_busy,
    output var  logic              ref_disable,
    output var  logic [2:0]        adc_gain_code,
    output var  logic              internal_divided_clock_tick,
    output var  logic              adc_mod_tick,
    output var  logic              dac_mod_tick,
    output var  logic              sample_tick,
    input  wire logic [CCC_SW-1:0] adc_in_data,
    input  wire logic              adc_in_valid,
    output var  logic [CCC_SW-1:0] adc_out_data,
    output var  logic              adc_out_valid,
    input  wire logic [CCC_SW-1:0] dac_in_data,
    input  wire logic              dac_in_valid,
    output var  logic              dac_in_ready,
    output var  logic [CCC_SW-1:0] dac_out_data,
    output var  logic              dac_out_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencing and mode strap
    ccc_state_t  state_q, state_d;
    logic [11:0] init_cnt_q, init_cnt_d;
    logic        slave_q, slave_d;
    logic        busy_q, busy_d;
    logic        run;

    always_comb begin
        state_d    = state_q;
        init_cnt_d = init_cnt_q;
        slave_d    = slave_q;
        busy_d     = busy_q;
        case (state_q)
            CCC_ST_RESET: begin
                slave_d    = serial_din;
                init_cnt_d = 12'h001;
                state_d    = CCC_ST_INIT;
            end
            CCC_ST_INIT: begin
                if (init_cnt_q == CCC_INIT_CYCLES) begin
                    state_d = CCC_ST_RUN;
                    busy_d  = 1'b0;
                end else begin
                    init_cnt_d = init_cnt_q + 12'h001;
                end
            end
            CCC_ST_RUN: begin
                state_d = CCC_ST_RUN;
            end
            default: begin
                state_d = CCC_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q    <= CCC_ST_RESET;
            init_cnt_q <= 12'h000;
            slave_q    <= 1'b0;
            busy_q     <= 1'b1;
        end else begin
            state_q    <= state_d;
            init_cnt_q <= init_cnt_d;
            slave_q    <= slave_d;
            busy_q     <= busy_d;
        end
    end

    assign run                 = (state_q == CCC_ST_RUN);
    assign slave_mode          = slave_q;
    assign init_busy           = busy_q;
    // Sync and bit clock pins are only driven once the strap says master
    logic drive_q;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= (state_q != CCC_ST_RESET) && !slave_d;
        end
    end
    assign serial_bit_clock_oe = drive_q;
    assign frame_sync_oe       = drive_q;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    logic       ref_dis_q, ref_dis_d;
    logic [1:0] div1_q, div1_d, div2_q, div2_d, div3_q, div3_d;
    logic       low_delay_q, low_delay_d;
    logic [2:0] gain_q, gain_d;
    logic       adc_mute_q, adc_mute_d;
    logic       peak_en_q, peak_en_d;
    logic [9:0] dac_vol_q, dac_vol_d;
    logic       dac_mute_q, dac_mute_d;
    logic       wr_ok;

    always_comb begin
        wr_ok       = reg_wr && run;
        ref_dis_d   = ref_dis_q;
        div1_d      = div1_q;
        div2_d      = div2_q;
        div3_d      = div3_q;
        low_delay_d = low_delay_q;
        gain_d      = gain_q;
        adc_mute_d  = adc_mute_q;
        peak_en_d   = peak_en_q;
        dac_vol_d   = dac_vol_q;
        dac_mute_d  = dac_mute_q;
        if (wr_ok) begin
            case (reg_addr)
                CCC_REG_REF_CTRL: begin
                    ref_dis_d = reg_wdata[CCC_REF_DIS_BIT];
                end
                CCC_REG_CLK_DIV: begin
                    div1_d = reg_wdata[CCC_DIV1_LSB +: 2];
                    div2_d = reg_wdata[CCC_DIV2_LSB +: 2];
                    div3_d = reg_wdata[CCC_DIV3_LSB +: 2];
                end
                CCC_REG_FILT_CTRL: begin
                    low_delay_d = reg_wdata[CCC_LOW_DELAY_BIT];
                end
                CCC_REG_ADC_CTRL: begin
                    // Codes above the top step saturate at 12 dB
                    gain_d = (reg_wdata[CCC_GAIN_LSB +: 3] > CCC_GAIN_MAX) ? CCC_GAIN_MAX
                                                                           : reg_wdata[CCC_GAIN_LSB +: 3];
                    adc_mute_d = reg_wdata[CCC_ADC_MUTE_BIT];
                    peak_en_d  = reg_wdata[CCC_PEAK_EN_BIT];
                end
                CCC_REG_DAC_VOL: begin
                    dac_vol_d = reg_wdata;
                end
                CCC_REG_DAC_CTRL: begin
                    dac_mute_d = reg_wdata[CCC_DAC_MUTE_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ref_dis_q   <= 1'b0;
            div1_q      <= CCC_DIV_BY1;
            div2_q      <= CCC_DIV_BY1;
            div3_q      <= CCC_DIV_BY1;
            low_delay_q <= 1'b0;
            gain_q      <= CCC_GAIN_RST;
            adc_mute_q  <= 1'b0;
            peak_en_q   <= 1'b0;
            dac_vol_q   <= CCC_DAC_VOL_RST;
            dac_mute_q  <= 1'b0;
        end else begin
            ref_dis_q   <= ref_dis_d;
            div1_q      <= div1_d;
            div2_q      <= div2_d;
            div3_q      <= div3_d;
            low_delay_q <= low_delay_d;
            gain_q      <= gain_d;
            adc_mute_q  <= adc_mute_d;
            peak_en_q   <= peak_en_d;
            dac_vol_q   <= dac_vol_d;
            dac_mute_q  <= dac_mute_d;
        end
    end

    assign ref_disable   = ref_dis_q;
    assign adc_gain_code = gain_q;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler cascade
    logic       t1, t2, t3;
    logic [1:0] last1, last2, last3;

    // Code 3 on the first two stages falls back to pass-through
    assign last1 = (div1_q == CCC_DIV_BY2) ? 2'h1 : (div1_q == CCC_DIV_BY3) ? 2'h2 : 2'h0;
    assign last2 = (div2_q == CCC_DIV_BY2) ? 2'h1 : (div2_q == CCC_DIV_BY3) ? 2'h2 : 2'h0;
    assign last3 = (div3_q == CCC_DIV_BY2) ? 2'h1 : (div3_q == CCC_DIV_BY4) ? 2'h3 : 2'h0;

    ccc_div_stage u_div1 (.clk(clk), .reset_n(reset_n), .clear(!run), .tick_in(1'b1), .last(last1), .tick_out(t1));
    ccc_div_stage u_div2 (.clk(clk), .reset_n(reset_n), .clear(!run), .tick_in(t1), .last(last2), .tick_out(t2));
    ccc_div_stage u_div3 (.clk(clk), .reset_n(reset_n), .clear(!run), .tick_in(t2), .last(last3), .tick_out(t3));

    assign internal_divided_clock_tick = t3;

    ////////////////////////////////////////////////////////////////////////////
    // Sample and modulator ticks from the divided clock
    logic [7:0] ph_q, ph_d;
    logic       smp_q, smp_d, adm_q, adm_d, dam_q, dam_d;

    always_comb begin
        ph_d  = ph_q;
        smp_d = 1'b0;
        adm_d = 1'b0;
        dam_d = 1'b0;
        if (!run) begin
            ph_d = 8'h00;
        end else if (t3) begin
            ph_d  = ph_q + 8'h01;
            adm_d = (ph_q[1:0] == CCC_ADC_MOD_PH);
            dam_d = ph_q[0];
            if (low_delay_q) begin
                smp_d = (ph_q[6:0] == CCC_FAST_LAST);
            end else begin
                smp_d = (ph_q == CCC_NORM_LAST);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ph_q  <= 8'h00;
            smp_q <= 1'b0;
            adm_q <= 1'b0;
            dam_q <= 1'b0;
        end else begin
            ph_q  <= ph_d;
            smp_q <= smp_d;
            adm_q <= adm_d;
            dam_q <= dam_d;
        end
    end

    assign sample_tick  = smp_q;
    assign adc_mod_tick = adm_q;
    assign dac_mod_tick = dam_q;

    ////////////////////////////////////////////////////////////////////////////
    // ADC output and peak tracking
    logic [CCC_SW-1:0] adc_q, adc_d, mag;
    logic              adc_v_q, adc_v_d, rd_peak;
    logic [5:0]        peak_q, peak_d, base, lvl;

    always_comb begin
        mag     = adc_in_data[CCC_SW-1] ? CCC_SW'(-adc_in_data) : adc_in_data;
        lvl     = ccc_peak_level(mag);
        rd_peak = reg_rd && (reg_addr == CCC_REG_PEAK_LEVEL);
        adc_v_d = adc_in_valid && run;
        adc_d   = adc_q;
        if (adc_in_valid) begin
            adc_d = adc_mute_q ? '0 : adc_in_data;
        end
        // A sample landing on the clearing read still counts
        base   = rd_peak ? CCC_PEAK_CLEAR : peak_q;
        peak_d = base;
        if (!peak_en_q || !run) begin
            peak_d = CCC_PEAK_CLEAR;
        end else if (adc_in_valid && (lvl < base)) begin
            peak_d = lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            adc_q   <= '0;
            adc_v_q <= 1'b0;
            peak_q  <= CCC_PEAK_CLEAR;
        end else begin
            adc_q   <= adc_d;
            adc_v_q <= adc_v_d;
            peak_q  <= peak_d;
        end
    end

    assign adc_out_data  = adc_q;
    assign adc_out_valid = adc_v_q;

    ////////////////////////////////////////////////////////////////////////////
    // DAC path: buffer drained once per sample tick
    logic              buf_v;
    logic [CCC_SW-1:0] buf_data;
    logic              take;
    logic [CCC_SW-1:0] dac_q, dac_d, scaled;
    logic              dac_v_q, dac_v_d;
    logic signed [27:0] prod;

    assign take = smp_d && buf_v;

    ccc_buf2 u_buf (
        .clk      (clk),
        .reset_n  (reset_n),
        .flush    (!run),
        .in_valid (dac_in_valid),
        .in_ready (dac_in_ready),
        .in_data  (dac_in_data),
        .out_valid(buf_v),
        .out_ready(take),
        .out_data (buf_data)
    );

    always_comb begin
        // Full scale at attenuation 0, one 1/1024 step per code
        prod    = $signed(buf_data) * $signed({1'b0, CCC_UNITY_GAIN - {1'b0, dac_vol_q}});
        scaled  = prod[25:10];
        dac_v_d = smp_d;
        dac_d   = dac_q;
        if (take) begin
            dac_d = dac_mute_q ? '0 : scaled;
        end else if (smp_d && dac_mute_q) begin
            dac_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dac_q   <= '0;
            dac_v_q <= 1'b0;
        end else begin
            dac_q   <= dac_d;
            dac_v_q <= dac_v_d;
        end
    end

    assign dac_out_data  = dac_q;
    assign dac_out_valid = dac_v_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data valid the cycle after the strobe
    logic [CCC_DW-1:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                CCC_REG_REF_CTRL:   rdata_d = {9'h000, ref_dis_q};
                CCC_REG_CLK_DIV:    rdata_d = {4'h0, div3_q, div2_q, div1_q};
                CCC_REG_FILT_CTRL:  rdata_d = {9'h000, low_delay_q};
                CCC_REG_ADC_CTRL:   rdata_d = {5'h00, peak_en_q, adc_mute_q, gain_q};
                CCC_REG_PEAK_LEVEL: rdata_d = {4'h0, peak_q};
                CCC_REG_DAC_VOL:    rdata_d = dac_vol_q;
                CCC_REG_DAC_CTRL:   rdata_d = {9'h000, dac_mute_q};
                CCC_REG_STATUS:     rdata_d = {8'h00, busy_q, slave_q};
                default:            rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : ccc_core
`default_nettype wire

// *** ccc_core_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccc_core_props
    import ccc_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              reg_rd,
    input wire logic [CCC_DW-1:0] reg_rdata,
    input wire logic              serial_din,
    input wire logic              slave_mode,
    input wire logic              serial_bit_clock_oe,
    input wire logic              frame_sync_oe,
    input wire logic              init_busy,
    input wire logic              adc_mod_tick,
    input wire logic              dac_mod_tick,
    input wire logic              sample_tick,
    input wire logic              adc_in_valid,
    input wire logic              adc_out_valid,
    input wire logic              dac_out_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic        arm_q;
    logic        strap_q;
    logic [11:0] init_q;
    logic [9:0]  gap_q;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arm_q  <= 1'b1;
            init_q <= 12'h000;
            gap_q  <= 10'h3ff;
        end else begin
            arm_q <= 1'b0;
            if (arm_q) strap_q <= serial_din;
            if (init_busy) init_q <= init_q + 12'h001;
            gap_q <= sample_tick ? 10'h000 : gap_q + {9'h0, gap_q != 10'h3ff};
        end
    end
    sequence adc_quiet;
        !adc_mod_tick [*3];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_strap_mode: assert property (!init_busy |-> slave_mode == strap_q)
        else $error("bad slave mode");
    a_master_drive: assert property (!init_busy |-> serial_bit_clock_oe == !slave_mode)
        else $error("bad oe");
    a_oe_pair: assert property (frame_sync_oe == serial_bit_clock_oe)
        else $error("oe pair differs");
    a_init_length: assert property ($fell(init_busy) |-> init_q == 12'd3073)
        else $error("init length wrong");
    a_init_quiet: assert property (init_busy |-> !sample_tick && !dac_out_valid)
        else $error("activity during init");
    a_adc_pass: assert property (adc_in_valid && !init_busy |=> adc_out_valid)
        else $error("adc dropped");
    a_dac_on_tick: assert property (dac_out_valid |-> sample_tick)
        else $error("dac output off tick");
    a_adc_mod_gap: assert property (adc_mod_tick |=> adc_quiet)
        else $error("adc mod fast");
    a_dac_mod_gap: assert property (dac_mod_tick |=> !dac_mod_tick)
        else $error("dac mod fast");
    a_sample_gap: assert property (sample_tick |-> gap_q >= 10'd127)
        else $error("ticks too close");
    a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved");
endmodule : ccc_core_props
bind ccc_core ccc_core_props i_props (.*);
`default_nettype wire

// *** ccc_dsp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccc_dsp_model
    import ccc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              strap,
    input  wire logic              dac_in_ready,
    output var  logic              serial_din,
    output var  logic              adc_in_valid,
    output var  logic [CCC_SW-1:0] adc_in_data,
    output var  logic              dac_in_valid,
    output var  logic [CCC_SW-1:0] dac_in_data
);
    logic [CCC_SW-1:0] q[$];
    initial begin
        {serial_din, adc_in_valid, dac_in_valid} = 3'b000;
        adc_in_data  = 16'h0000;
        dac_in_data  = 16'h0000;
    end
    // Strap held across reset release
    always @(posedge clk) serial_din <= strap;
    // Held until taken; idle data toggles
    always @(posedge clk) begin
        if (dac_in_valid && dac_in_ready) void'(q.pop_front());
        dac_in_valid <= q.size() > 0;
        dac_in_data  <= q.size() > 0 ? q[0] : ~dac_in_data;
    end
    task push(input logic [CCC_SW-1:0] w);
        q.push_back(w);
    endtask : push
    task adc(input logic [CCC_SW-1:0] w);
        @(posedge clk);
        adc_in_valid <= 1'b1;
        adc_in_data  <= w;
        @(posedge clk);
        adc_in_valid <= 1'b0;
        adc_in_data  <= ~w;
    endtask : adc
endmodule : ccc_dsp_model
`default_nettype wire

// *** tb_ccc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_ccc_core
    import ccc_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, strap = 1'b0;
    logic [2:0] reg_addr = 3'h0, adc_gain_code;
    logic [9:0] reg_wdata = 10'h000, reg_rdata;
    logic serial_din, slave_mode, serial_bit_clock_oe, frame_sync_oe, init_busy, ref_disable;
    logic internal_divided_clock_tick, adc_mod_tick, dac_mod_tick, sample_tick;
    logic adc_in_valid, adc_out_valid, dac_in_valid, dac_in_ready, dac_out_valid;
    logic [15:0] adc_in_data, adc_out_data, dac_in_data, dac_out_data;
    int fails = 0, n_compared = 0;
    always #10 clk = ~clk;
    ccc_core i_dut (.*);
    ccc_dsp_model i_dsp (.*);
    ////////////////////////////////////////////////////////////////////////////
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    task chk(input logic [16:0] s, input logic [16:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [2:0] a, input logic [9:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task rdc(input logic [2:0] a, input logic [9:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rdc
    task wt;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            if (sample_tick) return;
        end
        fails++;
        summarize();
    endtask : wt
    task gap(input int e);
        time t;
        wt();
        wt();
        t = $time;
        wt();
        chk(16'(($time - t) / 20), 16'(e));
    endtask : gap
    task rst(input logic s);
        reset_n <= 1'b0;
        strap   <= s;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        wr(CCC_REG_ADC_CTRL, 10'h01f);
        for (int i = 0; i < 4000 && init_busy !== 1'b0; i++) @(negedge clk);
        if (init_busy !== 1'b0) begin
            fails++;
            summarize();
        end
    endtask : rst
    initial begin
        rst(1'b0);
        chk(slave_mode, 1'b0);
        chk(serial_bit_clock_oe & frame_sync_oe, 1'b1);
        rdc(CCC_REG_ADC_CTRL, 10'h000);
        gap(256);
        chk(internal_divided_clock_tick, 1'b1);
        wr(CCC_REG_REF_CTRL, 10'h001);
        chk(ref_disable, 1'b1);
        for (int g = 0; g < 8; g++) begin
            wr(CCC_REG_ADC_CTRL, 10'(g));
            chk(adc_gain_code, g > 4 ? 16'h4 : 16'(g));
        end
        wr(CCC_REG_ADC_CTRL, 10'h010);
        i_dsp.adc(16'h4000);
        #1 chk(adc_out_data, 16'h4000);
        rdc(CCC_REG_PEAK_LEVEL, 10'h006);
        rdc(CCC_REG_PEAK_LEVEL, 10'h03f);
        wr(CCC_REG_ADC_CTRL, 10'h008);
        i_dsp.adc(16'h1234);
        #1 chk(adc_out_data, 16'h0000);
        wr(CCC_REG_DAC_VOL, 10'h200);
        wt();
        i_dsp.push(16'h2000);
        i_dsp.push(16'h0800);
        i_dsp.push(16'h4000);
        repeat (6) @(negedge clk);
        chk(dac_in_ready, 1'b0);
        wt();
        chk({dac_out_valid, dac_out_data}, 17'h11000);
        wt();
        chk(dac_out_data, 16'h0400);
        wt();
        chk(dac_out_data, 16'h2000);
        wr(CCC_REG_DAC_CTRL, 10'h001);
        wt();
        wt();
        chk(dac_out_data, 16'h0000);
        wr(CCC_REG_FILT_CTRL, 10'h001);
        gap(128);
        wr(CCC_REG_FILT_CTRL, 10'h000);
        wr(CCC_REG_CLK_DIV, 10'h002);
        gap(768);
        wr(CCC_REG_CLK_DIV, 10'h004);
        gap(512);
        wr(CCC_REG_CLK_DIV, 10'h020);
        gap(1024);
        rst(1'b1);
        chk(serial_bit_clock_oe, 1'b0);
        rdc(CCC_REG_STATUS, 10'h001);
        summarize();
    end
endmodule : tb_ccc_core
`default_nettype wire
